//--- bench/cache_ctl_assertions.sv
// Purpose: Port checks for cache_ctl
// Assumes: One clock domain
// Notes: Bound from the bench top file
`timescale 1ns/1ps
`default_nettype none
module cache_ctl_assertions (
  input wire clk_i,
  input wire rst_i,
  input wire cacheable_i,
  input wire read_grant_n_o,
  input wire write_grant_n_o,
  input wire read_ready_n_o,
  input wire write_ready_n_o,
  input wire write_strobe_permit_n_o,
  input wire data_oe_o,
  input wire write_qual_n_o,
  input wire cmd_n_o,
  input wire ctl_oe_o,
  input wire [2:0] block_dw_o,
  input wire fill_we_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_permit_then_write_ready_n: assert property ($fell(write_strobe_permit_n_o) |=> !write_ready_n_o) else $error("write_ready_n");
  a_permit_cached: assert property (!write_strobe_permit_n_o |-> cacheable_i) else $error("permit");
  a_nc_rdata: assert property (!read_ready_n_o && !cacheable_i |-> data_oe_o && read_grant_n_o) else $error("nc");
  a_fill_wgrant: assert property (fill_we_o |-> write_grant_n_o) else $error("fill wg");
  a_fill_rgrant: assert property (fill_we_o |-> read_grant_n_o) else $error("fill rg");
  a_fill_wrap: assert property (fill_we_o ##1 fill_we_o |-> block_dw_o == $past(block_dw_o) + 3'h1) else $error("wrap");
  a_inval_bus: assert property (!cmd_n_o |-> read_grant_n_o && write_grant_n_o && !write_qual_n_o && ctl_oe_o)
    else $error("inval");
  a_inval_release: assert property ($rose(cmd_n_o) |-> ctl_oe_o) else $error("release");
endmodule
`default_nettype wire

//--- bench/cache_ctl_bench.sv
// Purpose: Self-checking bench for cache_ctl
// Assumes: 50 MHz clock, short miss fetch
// Notes: Processor side played by cpu_model
`timescale 1ns/1ps
`default_nettype none
module cache_ctl_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cacheable_i = 1'b0;
  logic tag_hit_i = 1'b0;
  logic inval_req_i = 1'b0;
  wire command_strobe_n_i, read_n_i, write_n_i, burst_n_i, read_grant_n_o, write_grant_n_o, read_ready_n_o;
  wire write_ready_n_o, write_strobe_permit_n_o, data_oe_o, addr_oe_o, write_qual_n_o, cmd_n_o, ctl_oe_o;
  wire fill_we_o, inval_ack_o;
  // Doubleword size code
  wire transfer_size_hi_i = 1'b1;
  wire transfer_size_lo_i = 1'b1;
  wire [35:0] addr_i, addr_o;
  wire [35:0] inval_addr_i = 36'h0;
  wire [63:0] data_i = 64'h0;
  wire [63:0] fill_data_i = 64'h0123456789ABCDEF;
  wire [63:0] data_o;
  wire [2:0] block_dw_o;
  logic [63:0] rdys, wrdys, permits, fills, acks, rd_data;
  logic [2:0] first_dw;
  int errors = 0;
  int cmp_count = 0;
  int k;
  always #10 clk_i = ~clk_i;
  cache_ctl #(.FETCH_CYC(2)) u_dut (.*);
  cpu_model u_cpu (.clk_i(clk_i), .read_grant_n_i(read_grant_n_o), .write_grant_n_i(write_grant_n_o),
    .ready_n_i(read_ready_n_o & write_ready_n_o), .command_strobe_n_o(command_strobe_n_i),
    .read_n_o(read_n_i), .write_n_o(write_n_i), .burst_n_o(burst_n_i), .addr_o(addr_i));
  ////////////////////////////////////////////////////////////////
  always @(posedge clk_i)
  begin
    if (!read_ready_n_o) rdys++;
    if (!read_ready_n_o && data_oe_o) rd_data = data_o;
    if (!write_ready_n_o) wrdys++;
    if (!write_strobe_permit_n_o) permits++;
    if (inval_ack_o) acks++;
    if (fill_we_o && fills == 0) first_dw = block_dw_o;
    if (fill_we_o) fills++;
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Trailing idle cycles catch stray extra strobes
  task run(input logic c, input logic h, input logic w, input logic b, input logic [35:0] a, input int n);
    {rdys, wrdys, permits, fills, acks, rd_data} = 0;
    cacheable_i = c;
    tag_hit_i = h;
    u_cpu.op(w, b, a, n);
    repeat (8) @(negedge clk_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task t_wr_hit;
    run(1, 1, 1, 0, 36'h8, 1);
    chk(wrdys, 1);
    chk(permits, 1);
    $display("write hit done");
  endtask
  task t_wr_nc;
    run(0, 0, 1, 0, 36'h10, 1);
    chk(wrdys, 1);
    chk(permits, 0);
    $display("uncached write done");
  endtask
  task t_rd_nc;
    run(0, 0, 0, 0, 36'h18, 1);
    chk(rdys, 1);
    chk(rd_data, 64'h0123456789ABCDEF);
    $display("uncached read done");
  endtask
  task t_rd_hit;
    run(1, 1, 0, 1, 36'h20, 4);
    chk(rdys, 4);
    chk(fills, 0);
    $display("burst hit done");
  endtask
  task t_rd_miss;
    run(1, 0, 0, 1, 36'h28, 4);
    chk(rdys, 4);
    chk(fills, 8);
    chk(first_dw, 3'h5);
    $display("burst miss done");
  endtask
  task t_inval;
    acks = 0;
    repeat (2)
    begin
      inval_req_i = 1'b1;
      @(negedge clk_i) inval_req_i = 1'b0;
      for (k = 0; k < 50 && !inval_ack_o; k++) @(negedge clk_i);
      @(negedge clk_i);
    end
    chk(acks, 2);
    $display("invalidate done");
  endtask
  task summarize;
    chk(u_cpu.timeouts, 0);
    $display("%0d compares, %0d mismatches", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    t_wr_hit;
    t_wr_nc;
    t_rd_nc;
    t_rd_hit;
    t_rd_miss;
    t_inval;
    summarize;
  end
  initial
  begin
    #100000;
    errors++;
    summarize;
  end
endmodule
bind cache_ctl cache_ctl_assertions u_chk (.*);
`default_nettype wire

//--- bench/cpu_model.sv
// Purpose: Processor side of the bus
// Assumes: Drives on falling edges
// Notes: Ready lines joined, keepers hold controls high
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  input wire clk_i,
  input wire read_grant_n_i,
  input wire write_grant_n_i,
  input wire ready_n_i,
  output logic command_strobe_n_o,
  output logic read_n_o,
  output logic write_n_o,
  output logic burst_n_o,
  output logic [35:0] addr_o
);
  int i;
  int k;
  int timeouts = 0;
  initial
  begin
    {command_strobe_n_o, read_n_o, write_n_o, burst_n_o, addr_o} = {4'hF, 36'h0};
  end
  task op(input logic w, input logic b, input logic [35:0] a, input int n);
    for (k = 0; k < 99 && (w ? write_grant_n_i : read_grant_n_i); k++) @(negedge clk_i);
    if (k >= 99) timeouts++;
    {command_strobe_n_o, read_n_o, write_n_o, burst_n_o, addr_o} = {1'b0, w, !w, !b, a};
    @(negedge clk_i) command_strobe_n_o = 1'b1;
    for (i = 0, k = 0; i < n && k < 99; k++)
    begin
      @(posedge clk_i);
      if (!ready_n_i) i++;
    end
    if (i < n) timeouts++;
    @(negedge clk_i) {read_n_o, write_n_o, burst_n_o} = 3'h7;
  endtask
endmodule
`default_nettype wire

//--- rtl/cache_ctl.v
// Purpose: External cache controller facing the processor bus: grants, ready strobes, write permit, invalidates
// Assumes: Pins synchronous to clk_i; tag lookup and fills supplied by user side
// Notes: Drives active-low control pins with output enables
// Bus rules for this block and the processor side
// RULE1 - Uncached read: drop grant, then data and ready
// RULE2 - Uncached write ends with ready, no permit
// RULE3 - Processor drives address, qualifiers, output enable
// RULE4 - Hit read: ready with SRAM data
// RULE5 - Data two cycles after output enable
// RULE6 - Processor drives controls inactive before release
// RULE7 - Read miss: drop read grant, fetch
// RULE8 - Fill: drop write grant, ready on word
// RULE9 - Burst hit: ready every beat
// RULE10 - Miss stores whole block, passes half
// RULE11 - Burst data critical word first, wrapping
// RULE12 - Write hit permit at strobe plus two
// RULE13 - Write hit ready at strobe plus three
// RULE14 - Burst write: ready per doubleword
// RULE15 - Processor drops burst before last write
// RULE16 - Accept any burst write length, size
// RULE17 - Grant withdrawal cuts burst; resumes later
// RULE18 - Invalidate: revoke grants, drive address, strobe
// RULE19 - Processor accepts back-to-back invalidates
// RULE20 - Reads start only under read grant
// RULE21 - Byte strobes only while permit low
// RULE22 - Size code: byte,half,word,doubleword
// RULE23 - Write qualifier doubles as invalidate input
// RULE24 - Offsets counted from command strobe
`timescale 1ns/1ps
`default_nettype none
`include "cache_ctl_consts.vh"
module cache_ctl #(
  parameter ADDR_W = 36,
  parameter FETCH_CYC = `MISS_FETCH_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire command_strobe_n_i,
  input wire read_n_i,
  input wire write_n_i,
  input wire burst_n_i,
  input wire cacheable_i,
  input wire [ADDR_W-1:0] addr_i,
  input wire transfer_size_hi_i,
  input wire transfer_size_lo_i,
  input wire [63:0] data_i,
  input wire [63:0] fill_data_i,
  input wire tag_hit_i,
  input wire inval_req_i,
  input wire [ADDR_W-1:0] inval_addr_i,
  output wire read_grant_n_o,
  output wire write_grant_n_o,
  output wire read_ready_n_o,
  output wire write_ready_n_o,
  output wire write_strobe_permit_n_o,
  output reg [63:0] data_o,
  output reg data_oe_o,
  output reg [ADDR_W-1:0] addr_o,
  output reg addr_oe_o,
  output wire write_qual_n_o,
  output wire cmd_n_o,
  output wire ctl_oe_o,
  output reg [2:0] block_dw_o,
  output reg fill_we_o,
  output reg inval_ack_o
);
  localparam S_IDLE = 4'h0;
  localparam S_RD_HIT = 4'h1;
  localparam S_FETCH = 4'h2;
  localparam S_FILL = 4'h3;
  localparam S_WR_HIT = 4'h4;
  localparam S_WR_NC = 4'h5;
  localparam S_INV_REV = 4'h6;
  localparam S_INV_CMD = 4'h7;
  localparam S_INV_END = 4'h8;
  localparam S_RD_NC = 4'h9;

  ////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [6:0] pin_s1_q;
  reg [6:0] pin_s2_q;
  reg [ADDR_W-1:0] addr_s1_q;
  reg [ADDR_W-1:0] addr_s2_q;
  wire cmd_v = ~pin_s2_q[0];
  wire rd_v = ~pin_s2_q[1];
  wire wr_v = ~pin_s2_q[2];
  wire burst_v = ~pin_s2_q[3];
  wire cach_v = pin_s2_q[4];
  wire hit_v = pin_s2_q[5];
  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      pin_s1_q <= 7'h0F;
      pin_s2_q <= 7'h0F;
      addr_s1_q <= {ADDR_W{1'b0}};
      addr_s2_q <= {ADDR_W{1'b0}};
    end
    else
    begin
      pin_s1_q <= {inval_req_i, tag_hit_i, cacheable_i, burst_n_i, write_n_i, read_n_i, command_strobe_n_i};
      pin_s2_q <= pin_s1_q;
      addr_s1_q <= addr_i;
      addr_s2_q <= addr_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Control
  reg [3:0] st_q;
  reg [3:0] cyc_q;
  reg [15:0] wait_q;
  reg [2:0] start_q;
  reg [2:0] idx_q;
  reg [3:0] beat_q;
  reg burst_q;
  reg read_grant_n_q;
  reg write_grant_n_q;
  reg read_ready_n_q;
  reg write_ready_n_q;
  reg permit_q;
  reg cmd_q;
  reg ctl_oe_q;
  assign read_grant_n_o = ~read_grant_n_q;
  assign write_grant_n_o = ~write_grant_n_q;
  assign read_ready_n_o = ~read_ready_n_q;
  assign write_ready_n_o = ~write_ready_n_q;
  assign write_strobe_permit_n_o = ~permit_q;
  assign cmd_n_o = ~cmd_q;
  assign write_qual_n_o = ~cmd_q;
  assign ctl_oe_o = ctl_oe_q;
  wire [2:0] next_idx = idx_q + 3'h1;
  // Fetch count cut to the wait counter on purpose
  wire [31:0] fetch_full = FETCH_CYC;

  always @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      st_q <= S_IDLE;
      cyc_q <= 4'h0;
      wait_q <= 16'h0000;
      start_q <= 3'h0;
      idx_q <= 3'h0;
      beat_q <= 4'h0;
      burst_q <= 1'b0;
      read_grant_n_q <= 1'b0;
      write_grant_n_q <= 1'b0;
      read_ready_n_q <= 1'b0;
      write_ready_n_q <= 1'b0;
      permit_q <= 1'b0;
      cmd_q <= 1'b0;
      ctl_oe_q <= 1'b0;
      data_o <= 64'h0000000000000000;
      data_oe_o <= 1'b0;
      addr_o <= {ADDR_W{1'b0}};
      addr_oe_o <= 1'b0;
      block_dw_o <= 3'h0;
      fill_we_o <= 1'b0;
      inval_ack_o <= 1'b0;
    end
    else
    begin
      read_ready_n_q <= 1'b0;
      write_ready_n_q <= 1'b0;
      permit_q <= 1'b0;
      cmd_q <= 1'b0;
      fill_we_o <= 1'b0;
      inval_ack_o <= 1'b0;
      cyc_q <= (cyc_q == 4'hF) ? cyc_q : cyc_q + 4'h1;
      case (st_q)
        S_IDLE:
        begin
          read_grant_n_q <= 1'b1;
          write_grant_n_q <= 1'b1;
          data_oe_o <= 1'b0;
          addr_oe_o <= 1'b0;
          ctl_oe_q <= 1'b0;
          cyc_q <= 4'h1;
          idx_q <= addr_s2_q[5:3];
          start_q <= addr_s2_q[5:3];
          beat_q <= 4'h0;
          burst_q <= burst_v;
          if (pin_s2_q[6])
          begin
            read_grant_n_q <= 1'b0; // RULE18
            write_grant_n_q <= 1'b0; // RULE18
            st_q <= S_INV_REV;
          end
          else if (cmd_v && rd_v && read_grant_n_q) // RULE20 RULE24
          begin
            if (!cach_v)
            begin
              read_grant_n_q <= 1'b0; // RULE1
              wait_q <= fetch_full[15:0];
              st_q <= S_RD_NC;
            end
            else if (hit_v)
              st_q <= S_RD_HIT; // RULE3
            else
            begin
              read_grant_n_q <= 1'b0; // RULE7
              wait_q <= fetch_full[15:0];
              st_q <= S_FETCH;
            end
          end
          else if (cmd_v && wr_v && write_grant_n_q)
            st_q <= (cach_v && hit_v) ? S_WR_HIT : S_WR_NC;
        end
        S_RD_NC:
        begin
          wait_q <= wait_q - 16'h0001;
          if (wait_q == 16'h0001)
          begin
            write_grant_n_q <= 1'b0; // RULE1
            data_o <= fill_data_i;
            data_oe_o <= 1'b1;
            read_ready_n_q <= 1'b1; // RULE1
            st_q <= S_IDLE;
          end
        end
        S_RD_HIT:
        begin
          // SRAM registers OE, so data lands at strobe plus two
          if (cyc_q >= `OE_DATA_DLY) // RULE5
          begin
            read_ready_n_q <= 1'b1; // RULE4 RULE9
            beat_q <= beat_q + 4'h1;
            if (!burst_q || beat_q == `BURST_BEATS_HOST - 4'h1)
              st_q <= S_IDLE;
          end
        end
        S_FETCH:
        begin
          wait_q <= wait_q - 16'h0001;
          if (wait_q == 16'h0001)
          begin
            write_grant_n_q <= 1'b0; // RULE8
            beat_q <= 4'h0;
            st_q <= S_FILL;
          end
        end
        S_FILL:
        begin
          // Whole block written; only first beats reach the processor
          fill_we_o <= 1'b1; // RULE10
          block_dw_o <= idx_q;
          data_o <= fill_data_i;
          data_oe_o <= 1'b1;
          idx_q <= next_idx; // RULE11
          beat_q <= beat_q + 4'h1;
          if (beat_q == 4'h0 || (burst_q && beat_q < `BURST_BEATS_HOST))
            read_ready_n_q <= 1'b1; // RULE8 RULE10
          if (beat_q == `BLOCK_DW - 4'h1)
            st_q <= S_IDLE;
        end
        S_WR_HIT:
        begin
          if (!write_grant_n_q) // RULE17
          begin
            write_grant_n_q <= 1'b1;
            cyc_q <= 4'h1;
          end
          else if (cyc_q == `PERMIT_OFS)
            permit_q <= 1'b1; // RULE12
          else if (cyc_q == `WRITE_READY_N_OFS)
          begin
            write_ready_n_q <= 1'b1; // RULE13 RULE14
            // Burst pin already high means last write is this one
            if (!burst_v || pin_s2_q[6]) // RULE15 RULE16
            begin
              if (pin_s2_q[6])
                write_grant_n_q <= 1'b0; // RULE17
              st_q <= S_IDLE;
            end
            else
              cyc_q <= `PERMIT_OFS;
          end
        end
        S_WR_NC:
        begin
          if (cyc_q == `WRITE_READY_N_OFS)
          begin
            write_ready_n_q <= 1'b1; // RULE2
            st_q <= S_IDLE;
          end
        end
        S_INV_REV:
        begin
          addr_o <= inval_addr_i;
          addr_oe_o <= 1'b1; // RULE18
          ctl_oe_q <= 1'b1;
          cmd_q <= 1'b1; // RULE18 RULE23
          st_q <= S_INV_CMD;
        end
        S_INV_CMD:
        begin
          inval_ack_o <= 1'b1;
          // Drive inactive one cycle before release to keepers
          st_q <= pin_s2_q[6] ? S_INV_REV : S_INV_END; // RULE19
        end
        S_INV_END:
        begin
          ctl_oe_q <= 1'b0;
          addr_oe_o <= 1'b0;
          st_q <= S_IDLE;
        end
        default:
          st_q <= S_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- rtl/cache_ctl_consts.vh
// Purpose: Shared constants for the cache-side bus controller
// Assumes: 50 MHz clk_i
// Notes: Cycle offsets count from the command strobe cycle
`ifndef CACHE_CTL_CONSTS_VH
`define CACHE_CTL_CONSTS_VH
`define CMD_NONE 3'h0
`define CMD_RD_NC 3'h1
`define CMD_WR_NC 3'h2
`define CMD_RD_C 3'h3
`define CMD_WR_C 3'h4
`define CMD_INVAL 3'h5
`define PERMIT_OFS 4'h2
`define WRITE_READY_N_OFS 4'h3
`define OE_DATA_DLY 4'h2
`define SIZE_DW 2'h3
`define BURST_BEATS_HOST 4'h4
`define BLOCK_DW 4'h8
`define MISS_FETCH_NS 200
`define MISS_FETCH_CYC ((`MISS_FETCH_NS + 19) / 20)
`endif
